// *** pkg/ppcs_pkg.sv ***
// constants for the port phy control and status register bank
`default_nettype none
package ppcs_pkg;
  // register indices; byte address is four times the index
  localparam logic [2:0] IDX_DIAG = 3'h0;
  localparam logic [2:0] IDX_CTRL = 3'h2;
  localparam logic [2:0] IDX_STAT = 3'h4;
  // diagnostic control and status fields
  localparam int DG_SHORT = 15;
  localparam int DG_RES_HI = 14;
  localparam int DG_RES_LO = 13;
  localparam int DG_EN = 12;
  localparam int DG_FLINK = 11;
  localparam int DG_PSAVE = 10;
  localparam int DG_LOOP = 9;
  localparam int DG_CNT_HI = 8;
  // port control fields
  localparam int PC_LEDOFF = 15;
  localparam int PC_TXDIS = 14;
  localparam int PC_RESTART = 13;
  localparam int PC_MDIXDIS = 10;
  localparam int PC_FMDIX = 9;
  localparam int PC_ANEN = 7;
  localparam int PC_FSPEED = 6;
  localparam int PC_FDUPLEX = 5;
  localparam int ADV_HI = 4;
  // port status fields
  localparam int ST_XALG = 15;
  localparam int ST_POL = 13;
  localparam int ST_RXFC = 12;
  localparam int ST_TXFC = 11;
  localparam int ST_SPEED = 10;
  localparam int ST_DUPLEX = 9;
  localparam int ST_MDI = 7;
  localparam int ST_ANDONE = 6;
  localparam int ST_LINK = 5;
  // reset values
  localparam logic RST_PSAVE = 1'b1;
  localparam logic RST_ANEN = 1'b1;
  localparam logic [4:0] RST_ADV = 5'h1f;
  localparam logic RST_XALG = 1'b1;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // cable test outcome codes
  typedef enum logic [1:0] {
    PPCS_NORMAL = 2'h0,
    PPCS_OPEN = 2'h1,
    PPCS_SHORT = 2'h2,
    PPCS_FAILED = 2'h3
  } ppcs_result_type;
endpackage
`default_nettype wire

// *** rtl/ppcs_bank.sv ***
// axi4-lite register bank for port phy control and status
//
// The implementer's own choice: the AXI4-Lite register port.
`default_nettype none
module ppcs_bank #(
  parameter int ADDR_W = 5 // axi address width
) (
  input wire logic aclk, // bus clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic [2:0] s_axi_awprot, // write protection, unused
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic [2:0] s_axi_arprot, // read protection, unused
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic phy_test_done, // cable test finished, level
  input wire ppcs_pkg::ppcs_result_type phy_test_result, // test outcome
  input wire logic phy_near_short, // short under ten metres
  input wire logic [8:0] phy_fault_count, // distance to fault
  input wire logic phy_polarity_rev, // receive polarity reversed
  input wire logic phy_mdi, // one for mdi wiring
  input wire logic phy_rx_fc, // receive flow control active
  input wire logic phy_tx_fc, // transmit flow control active
  input wire logic phy_speed_100, // resolved speed
  input wire logic phy_full_duplex, // resolved duplex
  input wire logic phy_an_done, // negotiation complete
  input wire logic phy_an_fail, // negotiation failed
  input wire logic phy_link_good, // link good
  input wire logic [4:0] phy_partner_abil, // partner abilities
  input wire logic [3:0] led_activity, // normal indicator levels
  output logic diag_start, // cable test running
  output logic force_link_pass, // link forced to pass
  output logic power_save_disable, // power saving disabled
  output logic remote_loopback, // line loopback at phy
  output logic tx_disable, // transmitter stopped
  output logic an_restart, // one-cycle negotiation restart
  output logic an_enable, // negotiation enabled
  output logic auto_mdix_disable, // automatic crossover off
  output logic force_mdix, // mdi-x wiring forced
  output logic [4:0] advertise, // advertised abilities
  output logic crossover_algorithm_select, // crossover scheme
  output logic speed_100, // applied speed
  output logic full_duplex, // applied duplex
  output logic [3:0] port_indicator_out // port indicators
);
  import ppcs_pkg::*;

  localparam int SYNC_W = 31;

  if (ADDR_W < 5 || ADDR_W > 32) begin : g_addr_w_check
    $error("ADDR_W must lie between 5 and 32");
  end

  function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0] strb);
    logic [15:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction

  function automatic logic [2:0] reg_index(input logic [ADDR_W-1:0] addr);
    return addr[4:2];
  endfunction

  function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
    logic [2:0] idx;
    idx = addr[4:2];
    return (idx == IDX_DIAG || idx == IDX_CTRL || idx == IDX_STAT) &&
           (addr[1:0] == 2'h0) && (addr >> 5) == '0;
  endfunction

  // two-flop synchroniser for everything arriving from the phy
  logic [SYNC_W-1:0] sync_meta;
  logic [SYNC_W-1:0] sync_q;
  logic test_done_d;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_meta <= '0;
      sync_q <= '0;
      test_done_d <= 1'b0;
    end else begin
      sync_meta <= {led_activity, phy_an_fail, phy_partner_abil,
                    phy_link_good, phy_an_done, phy_full_duplex,
                    phy_speed_100, phy_tx_fc, phy_rx_fc, phy_mdi,
                    phy_polarity_rev, phy_fault_count, phy_near_short,
                    phy_test_result, phy_test_done};
      sync_q <= sync_meta;
      test_done_d <= sync_q[0];
    end
  end

  logic s_done;
  logic [1:0] s_result;
  logic s_short;
  logic [8:0] s_count;
  logic s_pol, s_mdi, s_rxfc, s_txfc, s_spd, s_dup, s_andone, s_link;
  logic [4:0] s_partner;
  logic s_anfail;
  logic [3:0] s_led;
  assign s_done = sync_q[0];
  assign s_result = sync_q[2:1];
  assign s_short = sync_q[3];
  assign s_count = sync_q[12:4];
  assign s_pol = sync_q[13];
  assign s_mdi = sync_q[14];
  assign s_rxfc = sync_q[15];
  assign s_txfc = sync_q[16];
  assign s_spd = sync_q[17];
  assign s_dup = sync_q[18];
  assign s_andone = sync_q[19];
  assign s_link = sync_q[20];
  assign s_partner = sync_q[25:21];
  assign s_anfail = sync_q[26];
  assign s_led = sync_q[30:27];

  logic test_end;
  assign test_end = s_done && !test_done_d;

  // write address and data are taken independently
  logic aw_held, w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic aw_take, w_take, do_write;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (aw_take) begin
      s_axi_awready <= 1'b0;
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b1;
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (w_take) begin
      s_axi_wready <= 1'b0;
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= is_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  logic wr_diag, wr_ctrl, wr_stat;
  logic [15:0] diag_new, ctrl_new, stat_new;
  assign wr_diag = do_write && is_mapped(aw_addr) && reg_index(aw_addr) == IDX_DIAG;
  assign wr_ctrl = do_write && is_mapped(aw_addr) && reg_index(aw_addr) == IDX_CTRL;
  assign wr_stat = do_write && is_mapped(aw_addr) && reg_index(aw_addr) == IDX_STAT;

  // diag and status bits are stored once; control bits are held in ctrl_reg and in the output flops, written together
  logic [15:0] diag_reg, ctrl_reg, stat_reg;
  assign diag_new = lane_merge(diag_reg, w_data, w_strb);
  assign ctrl_new = lane_merge(ctrl_reg, w_data, w_strb);
  assign stat_new = lane_merge(stat_reg, w_data, w_strb);

  // a software start wins over a test end in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      diag_start <= 1'b0;
    end else if (wr_diag && w_strb[1] && diag_new[DG_EN]) begin
      diag_start <= 1'b1;
    end else if (test_end) begin
      diag_start <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      force_link_pass <= 1'b0;
      power_save_disable <= RST_PSAVE;
      remote_loopback <= 1'b0;
    end else if (wr_diag && w_strb[1]) begin
      force_link_pass <= diag_new[DG_FLINK];
      power_save_disable <= diag_new[DG_PSAVE];
      remote_loopback <= diag_new[DG_LOOP];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_disable <= 1'b0;
      auto_mdix_disable <= 1'b0;
      force_mdix <= 1'b0;
      an_enable <= RST_ANEN;
      ctrl_reg <= {8'h00, RST_ANEN, 2'h0, RST_ADV};
      advertise <= RST_ADV;
    end else if (wr_ctrl) begin
      tx_disable <= ctrl_new[PC_TXDIS];
      auto_mdix_disable <= ctrl_new[PC_MDIXDIS];
      force_mdix <= ctrl_new[PC_FMDIX];
      an_enable <= ctrl_new[PC_ANEN];
      ctrl_reg <= ctrl_new;
      advertise <= ctrl_new[ADV_HI:0];
    end else begin
      ctrl_reg[PC_RESTART] <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      an_restart <= 1'b0;
    end else begin
      an_restart <= wr_ctrl && w_strb[1] && ctrl_new[PC_RESTART];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      crossover_algorithm_select <= RST_XALG;
    end else if (wr_stat && w_strb[1]) begin
      crossover_algorithm_select <= stat_new[ST_XALG];
    end
  end

  // only bit 15 of the status word holds state
  always_comb begin
    diag_reg = '0;
    diag_reg[DG_EN] = diag_start;
    diag_reg[DG_FLINK] = force_link_pass;
    diag_reg[DG_PSAVE] = power_save_disable;
    diag_reg[DG_LOOP] = remote_loopback;
    stat_reg = '0;
    stat_reg[ST_XALG] = crossover_algorithm_select;
  end

  // speed and duplex actually applied to the port
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      speed_100 <= 1'b0;
      full_duplex <= 1'b0;
    end else if (!an_enable) begin
      speed_100 <= ctrl_reg[PC_FSPEED];
      full_duplex <= ctrl_reg[PC_FDUPLEX];
    end else if (s_anfail) begin
      speed_100 <= s_spd;
      full_duplex <= ctrl_reg[PC_FDUPLEX];
    end else begin
      speed_100 <= s_spd;
      full_duplex <= s_dup;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_indicator_out <= '0;
    end else if (ctrl_reg[PC_LEDOFF]) begin
      port_indicator_out <= 4'hf;
    end else begin
      port_indicator_out <= s_led;
    end
  end

  // read side; results are shown live from the phy
  logic [15:0] diag_rd, ctrl_rd, stat_rd;
  always_comb begin
    diag_rd = diag_reg;
    diag_rd[DG_SHORT] = s_short;
    diag_rd[DG_RES_HI:DG_RES_LO] = s_result;
    diag_rd[DG_CNT_HI:0] = s_count;
    ctrl_rd = ctrl_reg;
    ctrl_rd[PC_TXDIS] = tx_disable;
    ctrl_rd[PC_MDIXDIS] = auto_mdix_disable;
    ctrl_rd[PC_FMDIX] = force_mdix;
    ctrl_rd[PC_ANEN] = an_enable;
    ctrl_rd[ADV_HI:0] = advertise;
    stat_rd = stat_reg;
    stat_rd[ST_POL] = s_pol;
    stat_rd[ST_RXFC] = s_rxfc;
    stat_rd[ST_TXFC] = s_txfc;
    stat_rd[ST_SPEED] = s_spd;
    stat_rd[ST_DUPLEX] = s_dup;
    stat_rd[ST_MDI] = s_mdi;
    stat_rd[ST_ANDONE] = s_andone;
    stat_rd[ST_LINK] = s_link;
    stat_rd[ADV_HI:0] = s_partner;
  end

  logic ar_take;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (ar_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      if (!is_mapped(s_axi_araddr)) begin
        s_axi_rdata <= '0;
      end else if (reg_index(s_axi_araddr) == IDX_DIAG) begin
        s_axi_rdata <= {16'h0000, diag_rd};
      end else if (reg_index(s_axi_araddr) == IDX_CTRL) begin
        s_axi_rdata <= {16'h0000, ctrl_rd};
      end else begin
        s_axi_rdata <= {16'h0000, stat_rd};
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // checks
  AST_TEST_END_CLEARS: assert property (@(posedge aclk) disable iff (!aresetn)
    test_end && !wr_diag |=> !diag_start)
    else $error("test enable not cleared at test end");
  AST_TEST_START: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_diag && w_strb[1] && w_data[DG_EN] |=> diag_start)
    else $error("test enable not set by write");
  AST_LED_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_reg[PC_LEDOFF] |=> port_indicator_out == 4'hf)
    else $error("indicators not high with led off");
  AST_RESTART_PULSE: assert property (@(posedge aclk) disable iff (!aresetn)
    an_restart |=> !an_restart)
    else $error("restart longer than one cycle");
  AST_RESTART_CAUSE: assert property (@(posedge aclk) disable iff (!aresetn)
    an_restart |-> $past(wr_ctrl) && $past(w_data[PC_RESTART]))
    else $error("restart without a write");
  AST_FORCED_SPEED: assert property (@(posedge aclk) disable iff (!aresetn)
    !an_enable |=> speed_100 == $past(ctrl_reg[PC_FSPEED]))
    else $error("forced speed not applied");
  AST_FAIL_DUPLEX: assert property (@(posedge aclk) disable iff (!aresetn)
    an_enable && s_anfail && !wr_ctrl |=> full_duplex == $past(ctrl_reg[PC_FDUPLEX]))
    else $error("forced duplex not applied on failed negotiation");
  AST_FORCE_LINK: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_diag && w_strb[1] |=> force_link_pass == $past(w_data[DG_FLINK]))
    else $error("force link not stored");
  AST_XALG: assert property (@(posedge aclk) disable iff (!aresetn)
    !wr_stat |=> $stable(crossover_algorithm_select))
    else $error("crossover select changed without write");
  AST_BVALID_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  COV_TEST: cover property (@(posedge aclk) disable iff (!aresetn)
    diag_start ##[1:1000] !diag_start);
  COV_RESTART: cover property (@(posedge aclk) disable iff (!aresetn) an_restart);
  COV_READ: cover property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && s_axi_rready);
endmodule // ppcs_bank
`default_nettype wire

// *** bench/ppcs_phy_model.sv ***
// behavioural phy side: cable test engine and line status sources
`default_nettype none
module ppcs_phy_model #(
  parameter int TEST_CYCLES = 20 // cable test length
) (
  input wire logic aclk, // clock
  input wire logic aresetn, // reset, active low
  input wire logic diag_start, // test enable from bank
  input wire ppcs_pkg::ppcs_result_type cfg_result, // outcome to report
  input wire logic cfg_short, // near short to report
  input wire logic [8:0] cfg_count, // fault distance to report
  input wire logic [15:0] cfg_stat, // line status, status layout
  input wire logic cfg_an_fail, // negotiation failure
  input wire logic [3:0] cfg_led, // indicator levels
  output logic phy_test_done, // test finished
  output ppcs_pkg::ppcs_result_type phy_test_result, // outcome
  output logic phy_near_short, // short under ten metres
  output logic [8:0] phy_fault_count, // fault distance
  output logic [15:0] phy_stat, // status lines
  output logic phy_an_fail, // negotiation failed
  output logic [3:0] led_activity // indicator levels
);
  import ppcs_pkg::*;
  logic [7:0] wait_cnt;
  logic start_q;
  logic done;
  logic busy;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_q <= 1'b0;
      done <= 1'b0;
      wait_cnt <= 8'h00;
    end else begin
      start_q <= diag_start;
      if (diag_start && !start_q) begin
        done <= 1'b0;
        wait_cnt <= TEST_CYCLES[7:0];
      end else if (wait_cnt != 8'h00) begin
        wait_cnt <= wait_cnt - 8'h01;
        if (wait_cnt == 8'h01) done <= 1'b1;
      end
    end
  end
  // results carry nothing useful while a test runs, else the configured outcome
  assign busy = wait_cnt != 8'h00;
  assign phy_test_done = done;
  assign phy_test_result = busy ? ppcs_result_type'(~cfg_result) : cfg_result;
  assign phy_near_short = busy ? ~cfg_short : cfg_short;
  assign phy_fault_count = busy ? ~cfg_count : cfg_count;
  assign phy_stat = cfg_stat;
  assign phy_an_fail = cfg_an_fail;
  assign led_activity = cfg_led;
endmodule // ppcs_phy_model
`default_nettype wire

// *** bench/ppcs_bank_tb_top.sv ***
// self-checking bench for the port phy register bank
`default_nettype none
module ppcs_bank_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import ppcs_pkg::*;
  localparam logic [4:0] A_DIAG = {IDX_DIAG, 2'h0};
  localparam logic [4:0] A_CTRL = {IDX_CTRL, 2'h0};
  localparam logic [4:0] A_STAT = {IDX_STAT, 2'h0};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [4:0] awaddr = 5'h00, araddr = 5'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h3;
  wire logic awready, wready, bvalid, arready, rvalid;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  ppcs_result_type cfg_result = PPCS_NORMAL;
  logic cfg_short = 1'b0, cfg_an_fail = 1'b0;
  logic [8:0] cfg_count = 9'h000;
  logic [15:0] cfg_stat = 16'h0000;
  logic [3:0] cfg_led = 4'h0;
  wire logic done, nshort, an_fail, diag_start, flink, psd, loopb, txd, rst_an, an_en;
  wire logic mdixd, fmdix, xsel, spd, fdx;
  wire ppcs_result_type result;
  wire logic [8:0] fcount;
  wire logic [15:0] stat;
  wire logic [3:0] leds, ind;
  wire logic [4:0] adv;
  int n_errors = 0, tests_run = 0, cyc = 0, n_pulse = 0;
  ppcs_phy_model ppcs_phy_model_i (.aclk(aclk), .aresetn(aresetn), .diag_start(diag_start),
    .cfg_result(cfg_result), .cfg_short(cfg_short), .cfg_count(cfg_count),
    .cfg_stat(cfg_stat), .cfg_an_fail(cfg_an_fail), .cfg_led(cfg_led),
    .phy_test_done(done), .phy_test_result(result), .phy_near_short(nshort),
    .phy_fault_count(fcount), .phy_stat(stat), .phy_an_fail(an_fail), .led_activity(leds));
  ppcs_bank ppcs_bank_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .phy_test_done(done),
    .phy_test_result(result), .phy_near_short(nshort), .phy_fault_count(fcount),
    .phy_polarity_rev(stat[13]), .phy_mdi(stat[7]), .phy_rx_fc(stat[12]),
    .phy_tx_fc(stat[11]), .phy_speed_100(stat[10]), .phy_full_duplex(stat[9]),
    .phy_an_done(stat[6]), .phy_an_fail(an_fail), .phy_link_good(stat[5]),
    .phy_partner_abil(stat[4:0]), .led_activity(leds), .diag_start(diag_start),
    .force_link_pass(flink), .power_save_disable(psd), .remote_loopback(loopb),
    .tx_disable(txd), .an_restart(rst_an), .an_enable(an_en), .auto_mdix_disable(mdixd),
    .force_mdix(fmdix), .advertise(adv), .crossover_algorithm_select(xsel),
    .speed_100(spd), .full_duplex(fdx), .port_indicator_out(ind));
  initial begin
    forever #50 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (rst_an === 1'b1) n_pulse++;
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    r = 2'bxx;
    forever begin
      @(posedge aclk);
      if (awready && awvalid) awvalid <= 1'b0;
      if (wready && wvalid) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arready && arvalid) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic wr_ok(input logic [4:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk("bresp", {30'h0, RESP_OKAY}, {30'h0, r});
    repeat (4) @(posedge aclk);
  endtask
  task automatic rd_chk(input string name, input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk("rresp", {30'h0, RESP_OKAY}, {30'h0, r});
    chk(name, exp, d);
  endtask
  task automatic t_reset();
    chk("reset outs", 32'hff0, {psd, an_en, adv, xsel, flink, loopb, txd, diag_start});
    rd_chk("diag rst", A_DIAG, 32'h0400);
    rd_chk("ctrl rst", A_CTRL, 32'h009f);
    rd_chk("stat rst", A_STAT, 32'h8000);
  endtask
  task automatic t_cable();
    for (int c = 0; c < 4; c++) begin
      cfg_result <= ppcs_result_type'(c);
      cfg_short <= c[0];
      cfg_count <= 9'h101 + 9'(c * 67);
      wr_ok(A_DIAG, 32'h1400);
      chk("test running", 32'h1, {31'h0, diag_start});
      for (int t = 0; t < 100 && diag_start !== 1'b0; t++) @(posedge aclk);
      repeat (4) @(posedge aclk);
      rd_chk("diag result", A_DIAG, {16'h0, c[0], 2'(c), 4'h2, 9'h101 + 9'(c * 67)});
    end
  endtask
  task automatic t_diag_ctrl();
    cfg_result <= PPCS_NORMAL;
    cfg_short <= 1'b0;
    cfg_count <= 9'h000;
    wr_ok(A_DIAG, 32'h0a00);
    chk("diag outs", 32'h5, {29'h0, flink, psd, loopb});
    rd_chk("diag ctrl", A_DIAG, 32'h0a00);
    wr_ok(A_DIAG, 32'h0400);
    chk("diag outs", 32'h2, {29'h0, flink, psd, loopb});
  endtask
  task automatic t_port_ctrl();
    cfg_led <= 4'h5;
    wr_ok(A_CTRL, 32'h409f);
    chk("tx off leds", 32'h15, {27'h0, txd, ind});
    wr_ok(A_CTRL, 32'h809f);
    chk("leds off", 32'h0f, {27'h0, txd, ind});
    cfg_stat <= 16'h0400;
    wr_ok(A_CTRL, 32'h0615);
    chk("forced slow", 32'h195, {an_en, mdixd, fmdix, spd, fdx, adv});
    rd_chk("ctrl mdix", A_CTRL, 32'h0615);
    wr_ok(A_CTRL, 32'h0060);
    chk("forced fast", 32'h060, {an_en, mdixd, fmdix, spd, fdx, adv});
    cfg_an_fail <= 1'b1;
    wr_ok(A_CTRL, 32'h00a0);
    chk("an failed", 32'h3, {30'h0, spd, fdx});
    cfg_an_fail <= 1'b0;
    repeat (4) @(posedge aclk);
    chk("an resolved", 32'h2, {30'h0, spd, fdx});
  endtask
  task automatic t_restart();
    n_pulse = 0;
    wr_ok(A_CTRL, 32'h209f);
    repeat (4) @(posedge aclk);
    chk("restart pulses", 32'h1, 32'(n_pulse));
    rd_chk("restart clr", A_CTRL, 32'h009f);
  endtask
  task automatic t_status();
    cfg_stat <= 16'h3eff;
    repeat (4) @(posedge aclk);
    rd_chk("status", A_STAT, 32'hbeff);
    wr_ok(A_STAT, 32'h0000);
    chk("xover sel", 32'h0, {31'h0, xsel});
    cfg_stat <= 16'h2095;
    repeat (4) @(posedge aclk);
    rd_chk("status", A_STAT, 32'h2095);
  endtask
  task automatic t_unmapped();
    logic [31:0] d;
    logic [1:0] r;
    wr(5'h0c, 32'hffff, r);
    chk("unmapped bresp", {30'h0, RESP_SLVERR}, {30'h0, r});
    rd(5'h0c, d, r);
    chk("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
    chk("unmapped rdata", 32'h0, d);
    rd(5'h02, d, r);
    chk("unaligned rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
    rd_chk("ctrl intact", A_CTRL, 32'h009f);
    wstrb <= 4'h1;
    wr_ok(A_CTRL, 32'hffe0);
    rd_chk("lane zero only", A_CTRL, 32'h00e0);
    wstrb <= 4'h3;
  endtask
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_cable();
    t_diag_ctrl();
    t_port_ctrl();
    t_restart();
    t_status();
    t_unmapped();
    final_report();
  end
endmodule // ppcs_bank_tb_top
`default_nettype wire
